/* File: p2io_top.sv */
// port 2 i/o block: registers, read mux, pin routing and drivers
//
// Notes on behaviour
// - eight-bit data register, read/write, resets zero
// - output pins read back the stored data
// - input pins read back the pin level
// - direction bit one means output
// - gpio settings apply only in gpio mode
// - direction register reads as all ones
// - reset makes every pin an input
// - function bits 7,6,4,3 read one, fixed
// - function register resets to D8
// - bit 5 turns serial-out pin open-drain
// - bit 2 routes pin 2 to serial out
// - bit 1 routes pin 1 to serial in
// - bit 0 makes pin 0 serial clock
// - per-pin bit selects open-drain output drive
// - open-drain selects reset to zero
// - float in reset/standby, hold when sleeping
//
// Our own choice: strobed register access.
`timescale 1ns/1ps
`default_nettype none
module p2io_top (
  input  wire logic                    ref_clk,
  input  wire logic                    rstn,
  input  wire logic [15:0]             addr,
  input  wire logic [7:0]              wr_data,
  input  wire logic                    wr_en,
  input  wire logic                    rd_en,
  output logic      [7:0]              rd_data_ff,
  input  wire p2io_pkg::p2io_mode_type  op_mode,
  input  wire logic [7:0]              pad_in,
  output logic      [7:0]              pad_out,
  output logic      [7:0]              pad_oe,
  input  wire p2io_pkg::p2io_ser_out_type ser_out,
  output p2io_pkg::p2io_ser_in_type    ser_in_ff
);
  import p2io_pkg::*;

  // software visible state
  logic [7:0]     out_data_ff;  // port output data
  logic [7:0]     direction_ff; // 1 = output
  logic [7:0]     open_drn_ff;  // 1 = nmos open drain
  logic [7:0]     pin_func_ff;  // writable function bits only

  // decoded access
  p2io_sel_type   wr_sel;       // write target
  p2io_sel_type   rd_sel;       // read target

  // derived views
  logic [7:0]     pin_func_rd;  // function register as read
  logic [7:0]     port_rd;      // port value as read
  logic [7:0]     nxt_rd_data;  // read mux output
  logic [7:0]     alt_sel;      // pin handed to serial unit
  logic [7:0]     alt_od;       // alternate pin is open drain
  p2io_drive_type alt_drv [8];  // alternate drive per pin
  p2io_drive_type pin_drv [8];  // resolved drive per pin
  logic [7:0]     nxt_pad_out;  // drive value before hold stage
  logic [7:0]     nxt_pad_oe;   // drive enable before hold stage
  logic           serial_out_pmos_off;
  logic           serial_out_pin_select;
  logic           serial_in_pin_select;
  logic           serial_clock_pin_select;

  // address decode, one function for both directions
  always_comb begin
    wr_sel = wr_en ? p2io_decode(addr) : P2IO_SEL_NONE;
    rd_sel = rd_en ? p2io_decode(addr) : P2IO_SEL_NONE;
  end

  // field views of the function register
  always_comb begin
    serial_out_pmos_off     = pin_func_ff[P2IO_BIT_PMOS_OFF];
    serial_out_pin_select   = pin_func_ff[P2IO_BIT_SO];
    serial_in_pin_select    = pin_func_ff[P2IO_BIT_SI];
    serial_clock_pin_select = pin_func_ff[P2IO_BIT_SCK];
  end

  // output data register
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      out_data_ff <= P2IO_RST_OUT_DATA;
    end else if (wr_sel == P2IO_SEL_DATA) begin
      out_data_ff <= wr_data;
    end
  end

  // direction register, write only
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      direction_ff <= P2IO_RST_DIRECTION;
    end else if (wr_sel == P2IO_SEL_DIR) begin
      direction_ff <= wr_data;
    end
  end

  // open drain select register
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      open_drn_ff <= P2IO_RST_OPEN_DRN;
    end else if (wr_sel == P2IO_SEL_OD) begin
      open_drn_ff <= wr_data;
    end
  end

  // function register: reserved bits are never stored,
  // so a write cannot disturb them
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      pin_func_ff <= P2IO_RST_PIN_FUNC & P2IO_PF_WR_MASK;
    end else if (wr_sel == P2IO_SEL_PF) begin
      pin_func_ff <= wr_data & P2IO_PF_WR_MASK;
    end
  end

  // reserved bits come back as ones
  always_comb begin
    pin_func_rd = pin_func_ff | P2IO_PF_RSVD_MASK;
  end

  // port read: stored data for outputs, pin level for inputs;
  // pad_in is taken as already synchronous to ref_clk
  always_comb begin
    port_rd = (direction_ff & out_data_ff)
            | (~direction_ff & pad_in);
  end

  // read mux, unmapped addresses answer zero
  always_comb begin
    case (rd_sel)
      P2IO_SEL_PF:   nxt_rd_data = pin_func_rd;
      P2IO_SEL_OD:   nxt_rd_data = open_drn_ff;
      P2IO_SEL_DATA: nxt_rd_data = port_rd;
      P2IO_SEL_DIR:  nxt_rd_data = P2IO_DIR_READ;
      default:       nxt_rd_data = P2IO_UNMAP_READ;
    endcase
  end

  // read data holds for one cycle only, zero otherwise
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      rd_data_ff <= 8'h00;
    end else begin
      rd_data_ff <= nxt_rd_data;
    end
  end

  // alternate routing of pins 2, 1 and 0
  always_comb begin
    alt_sel = 8'h00;
    alt_od  = 8'h00;
    for (int i = 0; i < 8; i++) begin
      alt_drv[i] = '0;
    end
    // serial data out, driver style from its own pmos bit
    alt_sel[P2IO_BIT_SO]     = serial_out_pin_select;
    alt_drv[P2IO_BIT_SO].out = ser_out.so_data;
    alt_drv[P2IO_BIT_SO].oe  = ser_out.so_oe;
    alt_od[P2IO_BIT_SO]      = serial_out_pmos_off;
    // serial data in, never driven
    alt_sel[P2IO_BIT_SI]     = serial_in_pin_select;
    // serial clock, both ways, enable from the serial unit
    alt_sel[P2IO_BIT_SCK]     = serial_clock_pin_select;
    alt_drv[P2IO_BIT_SCK].out = ser_out.sck_out;
    alt_drv[P2IO_BIT_SCK].oe  = ser_out.sck_oe;
  end

  // per pin driver; gpio settings only count without alternate
  for (genvar g = 0; g < 8; g++) begin : g_pin
    p2io_pin_cell u_cell (
      .use_alt (alt_sel[g]),
      .alt_drv (alt_drv[g]),
      .alt_od  (alt_od[g]),
      .dir     (direction_ff[g]),
      .data    (out_data_ff[g]),
      .od      (open_drn_ff[g]),
      .drv     (pin_drv[g])
    );
    assign nxt_pad_out[g] = pin_drv[g].out;
    assign nxt_pad_oe[g]  = pin_drv[g].oe;
  end

  // pad flops, mode dependent float and hold
  p2io_mode_hold u_hold (
    .ref_clk    (ref_clk),
    .rstn       (rstn),
    .op_mode    (op_mode),
    .nxt_out    (nxt_pad_out),
    .nxt_oe     (nxt_pad_oe),
    .pad_out_ff (pad_out),
    .pad_oe_ff  (pad_oe)
  );

  // serial inputs are registered so the unit sees clean levels;
  // costs one cycle of latency on serial data and clock
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      ser_in_ff <= '0;
    end else begin
      ser_in_ff.si_data <= serial_in_pin_select &
                           pad_in[P2IO_BIT_SI];
      ser_in_ff.sck_in  <= serial_clock_pin_select &
                           pad_in[P2IO_BIT_SCK];
    end
  end

  // helper: low only in the first cycle after reset release
  logic seen_ff;
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      seen_ff <= 1'b0;
    end else begin
      seen_ff <= 1'b1;
    end
  end

  // helper: current cycle is a plain running mode
  logic run_q;
  assign run_q = (op_mode == P2IO_ACTIVE) ||
                 (op_mode == P2IO_SUBACTIVE);

  a_reset_values: assert property (@(posedge ref_clk) disable iff (!rstn)
    !seen_ff |-> out_data_ff == 8'h00 && direction_ff == 8'h00 &&
                 open_drn_ff == 8'h00 && pin_func_rd == 8'hD8)
    else $error("register not at reset value");

  a_dir_reads_ones: assert property (@(posedge ref_clk) disable iff (!rstn)
    rd_en && addr == P2IO_OFS_DIRECTION |=> rd_data_ff == 8'hFF)
    else $error("direction read not all ones");

  a_rsvd_read_one: assert property (@(posedge ref_clk) disable iff (!rstn)
    rd_en && addr == P2IO_OFS_PIN_FUNC |=>
      (rd_data_ff & 8'hD8) == 8'hD8 &&
      (rd_data_ff & 8'h27) == $past(pin_func_ff))
    else $error("function register read wrong");

  a_rsvd_no_write: assert property (@(posedge ref_clk) disable iff (!rstn)
    wr_en && addr == P2IO_OFS_PIN_FUNC |=>
      pin_func_ff == ($past(wr_data) & 8'h27))
    else $error("function write not masked");

  a_out_readback: assert property (@(posedge ref_clk) disable iff (!rstn)
    rd_en && addr == P2IO_OFS_OUT_DATA |=>
      (rd_data_ff & $past(direction_ff)) ==
      ($past(out_data_ff) & $past(direction_ff)))
    else $error("output pin read not from data register");

  a_in_readback: assert property (@(posedge ref_clk) disable iff (!rstn)
    rd_en && addr == P2IO_OFS_OUT_DATA |=>
      (rd_data_ff & ~$past(direction_ff)) ==
      ($past(pad_in) & ~$past(direction_ff)))
    else $error("input pin read not from pin");

  a_gpio_enable: assert property (@(posedge ref_clk) disable iff (!rstn)
    run_q |=> pad_oe[7:3] ==
      $past(direction_ff[7:3] & ~(open_drn_ff[7:3] & out_data_ff[7:3])))
    else $error("gpio enable wrong");

  a_od_no_high: assert property (@(posedge ref_clk) disable iff (!rstn)
    run_q && open_drn_ff[7] && !alt_sel[7] |=> !(pad_oe[7] && pad_out[7]))
    else $error("open drain pin drove high");

  a_so_route: assert property (@(posedge ref_clk) disable iff (!rstn)
    run_q && serial_out_pin_select && !serial_out_pmos_off |=>
      pad_out[2] == $past(ser_out.so_data) &&
      pad_oe[2] == $past(ser_out.so_oe))
    else $error("serial out not routed");

  a_pmos_off: assert property (@(posedge ref_clk) disable iff (!rstn)
    run_q && serial_out_pin_select && serial_out_pmos_off |=>
      pad_out[2] == 1'b0 &&
      pad_oe[2] == $past(ser_out.so_oe & ~ser_out.so_data))
    else $error("serial out pmos not off");

  a_si_float: assert property (@(posedge ref_clk) disable iff (!rstn)
    run_q && serial_in_pin_select |=>
      !pad_oe[1] && ser_in_ff.si_data == $past(pad_in[1]))
    else $error("serial in pin wrong");

  a_sck_route: assert property (@(posedge ref_clk) disable iff (!rstn)
    run_q && serial_clock_pin_select |=>
      pad_oe[0] == $past(ser_out.sck_oe) &&
      ser_in_ff.sck_in == $past(pad_in[0]))
    else $error("serial clock pin wrong");

endmodule : p2io_top
`default_nettype wire

/* File: p2io_pkg.sv */
// constants, types and decode helper for the port 2 i/o block
`default_nettype none
package p2io_pkg;

  // bus widths
  localparam int P2IO_AW = 16;
  localparam int P2IO_DW = 8;

  // register byte addresses
  localparam logic [15:0] P2IO_OFS_PIN_FUNC  = 16'hFFC9;
  localparam logic [15:0] P2IO_OFS_OPEN_DRN  = 16'hFFCB;
  localparam logic [15:0] P2IO_OFS_OUT_DATA  = 16'hFFD5;
  localparam logic [15:0] P2IO_OFS_DIRECTION = 16'hFFE5;

  // reset values as seen by software
  localparam logic [7:0] P2IO_RST_PIN_FUNC  = 8'hD8;
  localparam logic [7:0] P2IO_RST_OPEN_DRN  = 8'h00;
  localparam logic [7:0] P2IO_RST_OUT_DATA  = 8'h00;
  localparam logic [7:0] P2IO_RST_DIRECTION = 8'h00;

  // pin function register layout
  localparam logic [7:0] P2IO_PF_RSVD_MASK = 8'hD8;
  localparam logic [7:0] P2IO_PF_WR_MASK   = 8'h27;
  localparam int P2IO_BIT_PMOS_OFF = 5;
  localparam int P2IO_BIT_SO       = 2;
  localparam int P2IO_BIT_SI       = 1;
  localparam int P2IO_BIT_SCK      = 0;

  // fixed read answers
  localparam logic [7:0] P2IO_DIR_READ   = 8'hFF;
  localparam logic [7:0] P2IO_UNMAP_READ = 8'h00;

  // operating modes of the chip
  typedef enum logic [2:0] {
    P2IO_ACTIVE    = 3'b000,
    P2IO_SUBACTIVE = 3'b001,
    P2IO_SLEEP     = 3'b010,
    P2IO_SUBSLEEP  = 3'b011,
    P2IO_WATCH     = 3'b100,
    P2IO_STANDBY   = 3'b101
  } p2io_mode_type;

  // register select
  typedef enum logic [2:0] {
    P2IO_SEL_NONE = 3'b000,
    P2IO_SEL_PF   = 3'b001,
    P2IO_SEL_OD   = 3'b010,
    P2IO_SEL_DATA = 3'b011,
    P2IO_SEL_DIR  = 3'b100
  } p2io_sel_type;

  // one pin's drive
  typedef struct packed {
    logic out;
    logic oe;
  } p2io_drive_type;

  // from the serial unit
  typedef struct packed {
    logic so_data;
    logic so_oe;
    logic sck_out;
    logic sck_oe;
  } p2io_ser_out_type;

  // to the serial unit
  typedef struct packed {
    logic si_data;
    logic sck_in;
  } p2io_ser_in_type;

  // address decode shared by read and write paths
  function automatic p2io_sel_type p2io_decode(input logic [15:0] addr);
    if (addr == P2IO_OFS_PIN_FUNC) begin
      return P2IO_SEL_PF;
    end else if (addr == P2IO_OFS_OPEN_DRN) begin
      return P2IO_SEL_OD;
    end else if (addr == P2IO_OFS_OUT_DATA) begin
      return P2IO_SEL_DATA;
    end else if (addr == P2IO_OFS_DIRECTION) begin
      return P2IO_SEL_DIR;
    end else begin
      return P2IO_SEL_NONE;
    end
  endfunction : p2io_decode

endpackage : p2io_pkg
`default_nettype wire

/* File: p2io_pin_cell.sv */
// one pin's output mux and cmos / open-drain driver model
`timescale 1ns/1ps
`default_nettype none
module p2io_pin_cell (
  input  wire logic                    use_alt,
  input  wire p2io_pkg::p2io_drive_type alt_drv,
  input  wire logic                    alt_od,
  input  wire logic                    dir,
  input  wire logic                    data,
  input  wire logic                    od,
  output var  p2io_pkg::p2io_drive_type drv
);
  import p2io_pkg::*;

  logic val;    // value the pin should show
  logic en;     // drive wanted at all
  logic od_eff; // pmos off

  // pick the controlling function
  always_comb begin
    if (use_alt) begin
      val    = alt_drv.out;
      en     = alt_drv.oe;
      od_eff = alt_od;
    end else begin
      val    = data;
      en     = dir;
      od_eff = od;
    end
  end

  // open drain only ever pulls low; a one releases the pin
  always_comb begin
    if (od_eff) begin
      drv.out = 1'b0;
      drv.oe  = en & ~val;
    end else begin
      drv.out = val;
      drv.oe  = en;
    end
  end

endmodule : p2io_pin_cell
`default_nettype wire

/* File: p2io_mode_hold.sv */
// pad output stage: float, hold or follow by operating mode
`timescale 1ns/1ps
`default_nettype none
module p2io_mode_hold (
  input  wire logic                ref_clk,
  input  wire logic                rstn,
  input  wire p2io_pkg::p2io_mode_type op_mode,
  input  wire logic [7:0]          nxt_out,
  input  wire logic [7:0]          nxt_oe,
  output logic      [7:0]          pad_out_ff,
  output logic      [7:0]          pad_oe_ff
);
  import p2io_pkg::*;

  // reset floats every pin; standby too, sleep-like modes freeze
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      pad_out_ff <= 8'h00;
      pad_oe_ff  <= 8'h00;
    end else begin
      case (op_mode)
        P2IO_STANDBY: begin
          pad_oe_ff <= 8'h00;
        end
        P2IO_SLEEP, P2IO_SUBSLEEP, P2IO_WATCH: begin
          pad_out_ff <= pad_out_ff;
          pad_oe_ff  <= pad_oe_ff;
        end
        default: begin
          pad_out_ff <= nxt_out;
          pad_oe_ff  <= nxt_oe;
        end
      endcase
    end
  end

  a_standby_float: assert property (@(posedge ref_clk) disable iff (!rstn)
    op_mode == P2IO_STANDBY |=> pad_oe_ff == 8'h00)
    else $error("pins driven in standby");

  a_sleep_freeze: assert property (@(posedge ref_clk) disable iff (!rstn)
    (op_mode == P2IO_SLEEP || op_mode == P2IO_WATCH ||
     op_mode == P2IO_SUBSLEEP) |=> $stable(pad_oe_ff) && $stable(pad_out_ff))
    else $error("pins moved while held");

endmodule : p2io_mode_hold
`default_nettype wire

/* File: p2io_board.sv */
// board model: resolves the wire level seen on each port pin
`timescale 1ns/1ps
`default_nettype none
module p2io_board (
  input  wire logic       ref_clk,
  input  wire logic [7:0] pad_out,
  input  wire logic [7:0] pad_oe,
  input  wire logic [7:0] ext_val,
  input  wire logic [7:0] ext_en,
  output logic      [7:0] pad_in
);
  logic [7:0] last_ff;  // wire level at the previous edge

  // device drive wins, then the board; a floating pin has no pull
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      if (pad_oe[i]) begin
        pad_in[i] = pad_out[i];
      end else if (ext_en[i]) begin
        pad_in[i] = ext_val[i];
      end else begin
        pad_in[i] = ~last_ff[i];  // undriven: level wanders each cycle
      end
    end
  end

  // remember the level so a float never looks like a stable value
  always_ff @(posedge ref_clk) begin
    last_ff <= pad_in;
  end
endmodule : p2io_board
`default_nettype wire

/* File: testbench.sv */
// self-checking bench for the port 2 i/o block
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import p2io_pkg::*;
  logic             ref_clk = 1'b0;  // 250 MHz
  logic             rstn = 1'b0;
  logic [15:0]      addr = 16'h0000;
  logic [7:0]       wr_data = 8'h00;
  logic             wr_en = 1'b0;
  logic             rd_en = 1'b0;
  logic [7:0]       rd_data_ff;
  p2io_mode_type    op_mode = P2IO_ACTIVE;
  logic [7:0]       pad_in;
  logic [7:0]       pad_out;
  logic [7:0]       pad_oe;
  p2io_ser_out_type ser_out = '0;
  p2io_ser_in_type  ser_in_ff;
  logic [7:0]       ext_val = 8'h3C;  // board level where dut is off
  logic [7:0]       ext_en = 8'hFF;   // board always holds the wire
  int               n_mismatch = 0;
  int               total_checks = 0;
  int               cyc = 0;
  logic [7:0]       m_pf, m_od, m_dir, m_dat;  // shadow registers
  p2io_mode_type    modes [6] = '{P2IO_SLEEP, P2IO_SUBSLEEP, P2IO_WATCH,
                                  P2IO_STANDBY, P2IO_SUBACTIVE, P2IO_ACTIVE};
  // corner configs {pf, od, dir, data}
  logic [31:0]      corner [4] = '{32'hFFFFFF00, 32'h00FFFFAA,
                                   32'h070000FF, 32'h2400FF55};

  p2io_top u_dut (.ref_clk(ref_clk), .rstn(rstn), .addr(addr),
    .wr_data(wr_data), .wr_en(wr_en), .rd_en(rd_en),
    .rd_data_ff(rd_data_ff), .op_mode(op_mode), .pad_in(pad_in),
    .pad_out(pad_out), .pad_oe(pad_oe), .ser_out(ser_out),
    .ser_in_ff(ser_in_ff));
  p2io_board u_board (.ref_clk(ref_clk), .pad_out(pad_out),
    .pad_oe(pad_oe), .ext_val(ext_val), .ext_en(ext_en), .pad_in(pad_in));

  // clock: 4 ns period
  always #2 ref_clk = ~ref_clk;

  // hang guard, well above the thousand or so cycles the run needs
  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_mismatch++;
      final_report();
    end
  end

  task automatic final_report();
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : final_report

  task automatic chk(input string what, input logic [7:0] exp,
                     input logic [7:0] got);
    total_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic wait_clk(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask : wait_clk

  // one-cycle write strobe
  task automatic bus_wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    wr_en <= 1'b1;
    addr <= a;
    wr_data <= d;
    @(posedge ref_clk);
    wr_en <= 1'b0;
  endtask : bus_wr

  // read data stand only in the cycle after the strobe
  task automatic rd_chk(input string what, input logic [15:0] a,
                        input logic [7:0] exp);
    @(posedge ref_clk);
    rd_en <= 1'b1;
    addr <= a;
    @(posedge ref_clk);
    rd_en <= 1'b0;
    #1;
    chk(what, exp, rd_data_ff);
  endtask : rd_chk

  // expected {oe, out} per pin from the shadow registers
  function automatic logic [15:0] exp_pad(input p2io_ser_out_type s);
    logic v, e, o;
    logic [15:0] r;
    r = '0;
    for (int i = 0; i < 8; i++) begin
      v = m_dat[i];
      e = m_dir[i];
      o = m_od[i];
      if (i == 2 && m_pf[2]) begin  // serial data out
        v = s.so_data;
        e = s.so_oe;
        o = m_pf[5];
      end
      if (i == 1 && m_pf[1]) begin  // serial data in, never driven
        e = 1'b0;
      end
      if (i == 0 && m_pf[0]) begin  // serial clock, always cmos
        v = s.sck_out;
        e = s.sck_oe;
        o = 1'b0;
      end
      r[8+i] = o ? (e & ~v) : e;
      r[i] = o ? 1'b0 : v;
    end
    return r;
  endfunction : exp_pad

  // pins, serial inputs and every register read back
  task automatic check_all(input logic [15:0] bad_a);
    logic [15:0] e;
    logic [7:0] lvl;
    e = exp_pad(ser_out);
    lvl = (e[15:8] & e[7:0]) | (~e[15:8] & ext_val);
    chk("pad_oe", e[15:8], pad_oe);
    chk("pad_out", e[7:0] & e[15:8], pad_out & e[15:8]);
    chk("ser_in", {6'h00, m_pf[1] & lvl[1], m_pf[0] & lvl[0]},
        {6'h00, ser_in_ff});
    rd_chk("pin_func", P2IO_OFS_PIN_FUNC, m_pf);
    rd_chk("open_drain", P2IO_OFS_OPEN_DRN, m_od);
    rd_chk("direction", P2IO_OFS_DIRECTION, 8'hFF);
    rd_chk("port_data", P2IO_OFS_OUT_DATA,
           (m_dir & m_dat) | (~m_dir & lvl));
    rd_chk("unmapped", bad_a, 8'h00);
  endtask : check_all

  task automatic cfg(input logic [31:0] c);
    bus_wr(P2IO_OFS_PIN_FUNC, c[31:24]);
    bus_wr(P2IO_OFS_OPEN_DRN, c[23:16]);
    bus_wr(P2IO_OFS_DIRECTION, c[15:8]);
    bus_wr(P2IO_OFS_OUT_DATA, c[7:0]);
    m_pf = (c[31:24] & 8'h27) | 8'hD8;  // fixed bits read one
    {m_od, m_dir, m_dat} = c[23:0];
  endtask : cfg

  initial begin
    logic [15:0] bad_a;
    logic [7:0] prev;
    void'($urandom(36216));
    wait_clk(4);
    chk("oe_in_reset", 8'h00, pad_oe);
    repeat (4) @(posedge ref_clk);
    rstn <= 1'b1;
    wait_clk(3);
    {m_pf, m_od, m_dir, m_dat} = 32'hD8000000;
    check_all(16'hFFC8);
    // corner cases first, then random configs
    for (int k = 0; k < 40; k++) begin
      cfg(k < 4 ? corner[k] : $urandom);
      bad_a = k < 4 ? 16'hFFCA : {8'h00, 8'($urandom)};
      bus_wr(bad_a, 8'($urandom));  // ignored write
      ser_out <= 4'($urandom);
      ext_val <= 8'($urandom);
      wait_clk(3);
      check_all(bad_a);
    end
    // operating modes: freeze, float or follow
    cfg(32'h0000FF0F);
    wait_clk(3);
    for (int k = 0; k < 6; k++) begin
      prev = m_dat;
      op_mode <= modes[k];
      wait_clk(2);
      cfg({8'h00, 8'h00, 8'hFF, 8'($urandom)});
      wait_clk(3);
      if (modes[k] == P2IO_STANDBY) begin
        chk("oe_standby", 8'h00, pad_oe);
      end else begin
        chk("oe_mode", 8'hFF, pad_oe);
        chk("out_mode", k < 3 ? prev : m_dat, pad_out);
      end
      op_mode <= P2IO_ACTIVE;
      wait_clk(3);
    end
    // reset in mid-run floats pins at once and restores defaults
    @(posedge ref_clk);
    rstn <= 1'b0;
    #1;
    chk("oe_reset", 8'h00, pad_oe);
    repeat (3) @(posedge ref_clk);
    rstn <= 1'b1;
    wait_clk(3);
    {m_pf, m_od, m_dir, m_dat} = 32'hD8000000;
    check_all(16'hFFE4);
    final_report();
  end
endmodule : testbench
`default_nettype wire
